// file: design/kis_regs.svh
// register offsets, field positions, reset values and counts for the keyed setting block
`ifndef KIS_REGS_SVH
`define KIS_REGS_SVH

`define KIS_ADDR_ACCURACY   16'he7e2
`define KIS_ADDR_UNLOCK     16'he7fe
`define KIS_ADDR_SAG_LEVEL  16'h4000
`define KIS_ADDR_ZX_TIMEOUT 16'h4001
`define KIS_ADDR_RUN        16'h4002
`define KIS_ADDR_STATUS     16'h4003

`define KIS_UNLOCK_KEY      8'had
`define KIS_ACCURACY_BEST   8'h01
`define KIS_ACCURACY_RESET  8'h00

`define KIS_RUN_BIT         0
`define KIS_ST_ARMED_BIT    0
`define KIS_ST_SEEN_BIT     1
`define KIS_ST_SAG_PEND_BIT 2
`define KIS_ST_ZX_PEND_BIT  3

`define KIS_SAG_RESET       32'h0000_0000
`define KIS_ZX_RESET        32'h0000_ffff

`define KIS_TAKEUP_PCT      40'h00_0000_000a
`define KIS_PCT_SCALE       40'h00_0000_0064
`define KIS_FORCE_WRITES    4'h8

`endif

// file: design/kis_pkg.sv
// types shared by the keyed setting block
package kis_pkg;

  typedef enum logic [1:0] {
    KIS_SZ_8  = 2'b00,
    KIS_SZ_16 = 2'b01,
    KIS_SZ_32 = 2'b10
  } kis_size_t;

  typedef enum logic [0:0] {
    KIS_KEY_IDLE  = 1'b0,
    KIS_KEY_ARMED = 1'b1
  } kis_key_state_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    kis_size_t   size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } kis_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } kis_rsp_t;

endpackage : kis_pkg

// file: design/kis_threshold_shadow.sv
// one threshold register with deferred take-up into its active copy
`timescale 1ns/1ps
`default_nettype none
`include "kis_regs.svh"
module kis_threshold_shadow #(
  parameter int          WIDTH     = 24,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // register side
  input  wire logic             wr,
  input  wire logic             other_access,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             takeup_ok,
  output var  logic [WIDTH-1:0] stored,
  output var  logic [WIDTH-1:0] active,
  output var  logic             pending
);

  logic [3:0] run_len;

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("kis_threshold_shadow: WIDTH must be 1 to 32");
  end

  // consecutive-write counter, broken by any other access
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_len <= 4'h0;
    end else if (ce) begin
      if (wr) begin
        run_len <= (run_len == `KIS_FORCE_WRITES) ? run_len : run_len + 4'h1;
      end else if (other_access) begin
        run_len <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stored <= RESET_VAL[WIDTH-1:0];
    end else if (ce && wr) begin
      stored <= wdata;
    end
  end

  // reset value is live at once; later writes wait for take-up or a run of eight
  always_ff @(posedge clk) begin
    if (!rstn) begin
      active  <= RESET_VAL[WIDTH-1:0];
      pending <= 1'b0;
    end else if (ce) begin
      if (wr && (takeup_ok || run_len == `KIS_FORCE_WRITES - 4'h1 ||
                 run_len == `KIS_FORCE_WRITES)) begin
        active  <= wdata;
        pending <= 1'b0;
      end else if (wr) begin
        pending <= 1'b1;
      end else if (pending && takeup_ok) begin
        active  <= stored;
        pending <= 1'b0;
      end
    end
  end

endmodule : kis_threshold_shadow
`default_nettype wire

// file: design/kis_top.sv
// keyed internal accuracy setting and deferred threshold take-up
`timescale 1ns/1ps
`default_nettype none
`include "kis_regs.svh"
module kis_top
  import kis_pkg::*;
#(
  parameter int          SAG_W       = 24,
  parameter int          ZX_W        = 16,
  parameter int          V_W         = 24,
  parameter int          NPHASE      = 3,
  parameter logic [31:0] V_FULLSCALE = 32'h0052_02b8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  // register access port
  input  wire kis_req_t              req,
  output var  kis_rsp_t              rsp,
  // phase voltage magnitudes from the metering path
  input  wire logic [NPHASE*V_W-1:0] phase_mag,
  // settings to the analog and detector logic
  output var  logic [7:0]            accuracy_setting,
  output var  logic                  run,
  output var  logic [SAG_W-1:0]      sag_level_threshold,
  output var  logic [ZX_W-1:0]       zero_cross_timeout,
  output var  logic                  takeup_seen
);

  if (SAG_W < 1 || SAG_W > 32 || ZX_W < 1 || ZX_W > 32 ||
      V_W < 1 || V_W > 32 || NPHASE < 1 || NPHASE > 8) begin : g_bad_params
    $error("kis_top: parameter out of supported range");
  end

  kis_key_state_t   key_state;
  kis_key_state_t   next_key_state;
  logic             acc_key;
  logic             acc_set;
  logic             acc_sag;
  logic             acc_zx;
  logic             acc_run;
  logic             acc_stat;
  logic             is_byte;
  logic             wr;
  logic             rd;
  logic [NPHASE-1:0] phase_above;
  logic             any_above;
  logic [SAG_W-1:0] sag_stored;
  logic [ZX_W-1:0]  zx_stored;
  logic             sag_pending;
  logic             zx_pending;
  logic [31:0]      next_rdata;

  // address decode
  assign acc_key  = req.addr == `KIS_ADDR_UNLOCK;
  assign acc_set  = req.addr == `KIS_ADDR_ACCURACY;
  assign acc_sag  = req.addr == `KIS_ADDR_SAG_LEVEL;
  assign acc_zx   = req.addr == `KIS_ADDR_ZX_TIMEOUT;
  assign acc_run  = req.addr == `KIS_ADDR_RUN;
  assign acc_stat = req.addr == `KIS_ADDR_STATUS;
  assign is_byte  = req.size == KIS_SZ_8;
  assign wr       = ce && req.valid && req.we;
  assign rd       = ce && req.valid && !req.we;

  // key sequence: armed only for the access directly after the key write
  always_comb begin
    next_key_state = key_state;
    case (key_state)
      KIS_KEY_IDLE: begin
        if (wr && acc_key && is_byte && req.wdata[7:0] == `KIS_UNLOCK_KEY) begin
          next_key_state = KIS_KEY_ARMED;
        end
      end
      KIS_KEY_ARMED: begin
        if (req.valid) begin
          next_key_state = KIS_KEY_IDLE;
          if (wr && acc_key && is_byte && req.wdata[7:0] == `KIS_UNLOCK_KEY) begin
            next_key_state = KIS_KEY_ARMED;
          end
        end
      end
      default: begin
        next_key_state = KIS_KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      key_state <= KIS_KEY_IDLE;
    end else if (ce) begin
      key_state <= next_key_state;
    end
  end

  // protected setting: a byte write taken only straight after the key
  always_ff @(posedge clk) begin
    if (!rstn) begin
      accuracy_setting <= `KIS_ACCURACY_RESET;
    end else if (wr && acc_set && is_byte && key_state == KIS_KEY_ARMED) begin
      accuracy_setting <= req.wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run <= 1'b0;
    end else if (wr && acc_run) begin
      run <= req.wdata[`KIS_RUN_BIT];
    end
  end

  // per-phase comparison against ten percent of full scale
  for (genvar p = 0; p < NPHASE; p++) begin : g_phase
    always_ff @(posedge clk) begin
      if (!rstn) begin
        phase_above[p] <= 1'b0;
      end else if (ce) begin
        phase_above[p] <= 40'(phase_mag[p*V_W +: V_W]) * `KIS_PCT_SCALE >
                          40'(V_FULLSCALE) * `KIS_TAKEUP_PCT;
      end
    end
  end

  assign any_above = |phase_above;

  // once any phase has been above the level, new thresholds apply directly
  always_ff @(posedge clk) begin
    if (!rstn) begin
      takeup_seen <= 1'b0;
    end else if (ce && any_above) begin
      takeup_seen <= 1'b1;
    end
  end

  kis_threshold_shadow #(
    .WIDTH     (SAG_W),
    .RESET_VAL (`KIS_SAG_RESET)
  ) u_sag (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .wr           (wr && acc_sag),
    .other_access (req.valid && !(req.we && acc_sag)),
    .wdata        (req.wdata[SAG_W-1:0]),
    .takeup_ok    (takeup_seen || any_above),
    .stored       (sag_stored),
    .active       (sag_level_threshold),
    .pending      (sag_pending)
  );

  kis_threshold_shadow #(
    .WIDTH     (ZX_W),
    .RESET_VAL (`KIS_ZX_RESET)
  ) u_zx (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .wr           (wr && acc_zx),
    .other_access (req.valid && !(req.we && acc_zx)),
    .wdata        (req.wdata[ZX_W-1:0]),
    .takeup_ok    (takeup_seen || any_above),
    .stored       (zx_stored),
    .active       (zero_cross_timeout),
    .pending      (zx_pending)
  );

  // read data; the key register and unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc_set) begin
      next_rdata[7:0] = accuracy_setting;
    end else if (acc_sag) begin
      next_rdata[SAG_W-1:0] = sag_stored;
    end else if (acc_zx) begin
      next_rdata[ZX_W-1:0] = zx_stored;
    end else if (acc_run) begin
      next_rdata[`KIS_RUN_BIT] = run;
    end else if (acc_stat) begin
      next_rdata[`KIS_ST_ARMED_BIT]    = key_state == KIS_KEY_ARMED;
      next_rdata[`KIS_ST_SEEN_BIT]     = takeup_seen;
      next_rdata[`KIS_ST_SAG_PEND_BIT] = sag_pending;
      next_rdata[`KIS_ST_ZX_PEND_BIT]  = zx_pending;
    end
  end

  // one response per access, one cycle after it is taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp <= '0;
    end else if (ce) begin
      rsp.valid <= req.valid;
      if (rd) begin
        rsp.rdata <= next_rdata;
      end else begin
        rsp.rdata <= 32'h0000_0000;
      end
    end
  end

endmodule : kis_top
`default_nettype wire

// file: verif/kis_host_model.sv
// host model driving the register access port
`timescale 1ns/1ps
`default_nettype none
`include "kis_regs.svh"
module kis_host_model
  import kis_pkg::*;
(
  // clock
  input  wire logic     clk,
  // register access port
  output var  kis_req_t req,
  input  wire kis_rsp_t rsp
);
  initial req = '0;
  // one access per cycle; caller enters just after a rising edge
  task automatic xfer(input logic we, input kis_size_t sz, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    req = '{1'b1, we, sz, a, d};
    @(posedge clk);
    #1;
    q = rsp.rdata;
  endtask : xfer
  // released we, addr and wdata lines show the inverse of the last value; size holds
  task automatic idle();
    req = '{1'b0, ~req.we, req.size, ~req.addr, ~req.wdata};
    @(posedge clk);
    #1;
  endtask : idle
  task automatic unlock(input logic [31:0] d, input kis_size_t sz);
    logic [31:0] q;
    xfer(1'b1, KIS_SZ_8, `KIS_ADDR_UNLOCK, {24'h00_0000, `KIS_UNLOCK_KEY}, q);
    xfer(1'b1, sz, `KIS_ADDR_ACCURACY, d, q);
  endtask : unlock
  task automatic burst8(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    for (int i = 0; i < 8; i++) xfer(1'b1, KIS_SZ_32, a, d, q);
  endtask : burst8
endmodule : kis_host_model
`default_nettype wire

// file: verif/kis_top_sva.sv
// assertions on the keyed setting block ports
`timescale 1ns/1ps
`default_nettype none
`include "kis_regs.svh"
module kis_top_sva
  import kis_pkg::*;
#(
  parameter int          SAG_W       = 24,
  parameter int          ZX_W        = 16,
  parameter int          V_W         = 24,
  parameter int          NPHASE      = 3,
  parameter logic [31:0] V_FULLSCALE = 32'h0052_02b8
) (
  // watched ports
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  ce,
  input wire kis_req_t              req,
  input wire kis_rsp_t              rsp,
  input wire logic [NPHASE*V_W-1:0] phase_mag,
  input wire logic [7:0]            accuracy_setting,
  input wire logic                  run,
  input wire logic [SAG_W-1:0]      sag_level_threshold,
  input wire logic [ZX_W-1:0]       zero_cross_timeout,
  input wire logic                  takeup_seen
);
  logic acc, key_wr, set_wr, above, armed;
  always_comb begin
    acc = ce && req.valid;
    key_wr = acc && req.we && req.size == KIS_SZ_8 && req.addr == `KIS_ADDR_UNLOCK
             && req.wdata[7:0] == `KIS_UNLOCK_KEY;
    set_wr = acc && req.we && req.size == KIS_SZ_8 && req.addr == `KIS_ADDR_ACCURACY;
    above = 1'b0;
    for (int p = 0; p < NPHASE; p++)
      if (40'(phase_mag[p*V_W +: V_W]) * `KIS_PCT_SCALE > 40'(V_FULLSCALE) * `KIS_TAKEUP_PCT)
        above = 1'b1;
  end
  // any access other than the key disarms
  always_ff @(posedge clk) begin
    if (!rstn) armed <= 1'b0;
    else if (acc) armed <= key_wr;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  rsp_pulse_a: assert property (ce |=> rsp.valid == $past(req.valid))
    else $error("response pulse mismatch");
  key_capture_a: assert property (key_wr ##1 set_wr |=>
    accuracy_setting == $past(req.wdata[7:0])) else $error("keyed setting not captured");
  setting_guard_a: assert property (!(set_wr && armed) |=> $stable(accuracy_setting))
    else $error("setting changed without key");
  reset_default_a: assert property (disable iff (1'b0) !rstn |=>
    accuracy_setting == `KIS_ACCURACY_RESET && zero_cross_timeout == ZX_W'(`KIS_ZX_RESET)
    && sag_level_threshold == SAG_W'(`KIS_SAG_RESET) && !takeup_seen && !run && !rsp.valid)
    else $error("reset values wrong");
  setting_readback_a: assert property (acc && !req.we && req.addr == `KIS_ADDR_ACCURACY
    |=> rsp.rdata[7:0] == $past(accuracy_setting)) else $error("setting read back wrong");
  sag_takeup_a: assert property (acc && req.we && req.addr == `KIS_ADDR_SAG_LEVEL
    && takeup_seen |=> sag_level_threshold == $past(req.wdata[SAG_W-1:0]))
    else $error("sag level not taken up");
  zx_takeup_a: assert property (acc && req.we && req.addr == `KIS_ADDR_ZX_TIMEOUT
    && takeup_seen |=> zero_cross_timeout == $past(req.wdata[ZX_W-1:0]))
    else $error("timeout not taken up");
  takeup_flag_a: assert property (ce && above ##1 ce |=> takeup_seen)
    else $error("phase level not noticed");
endmodule : kis_top_sva
bind kis_top kis_top_sva #(.SAG_W(SAG_W), .ZX_W(ZX_W), .V_W(V_W), .NPHASE(NPHASE),
  .V_FULLSCALE(V_FULLSCALE)) u_sva (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .rsp(rsp),
  .phase_mag(phase_mag), .accuracy_setting(accuracy_setting), .run(run),
  .sag_level_threshold(sag_level_threshold), .zero_cross_timeout(zero_cross_timeout),
  .takeup_seen(takeup_seen));
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the keyed setting block
`timescale 1ns/1ps
`default_nettype none
`include "kis_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import kis_pkg::*;
;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic        ce        = 1'b1;
  logic [71:0] phase_mag = '0;
  kis_req_t    req;
  kis_rsp_t    rsp;
  logic [7:0]  acc;
  logic        run;
  logic [23:0] sag;
  logic [15:0] zx;
  logic        seen;
  logic [31:0] q;
  int          fails     = 0;
  int          n_checks  = 0;
  int          cycles    = 0;
  always #2.5 clk = ~clk;
  kis_host_model host (.clk(clk), .req(req), .rsp(rsp));
  kis_top uut (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .rsp(rsp), .phase_mag(phase_mag),
    .accuracy_setting(acc), .run(run), .sag_level_threshold(sag), .zero_cross_timeout(zx),
    .takeup_seen(seen));
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      summarize();
    end
  end
  task automatic rd(input logic [15:0] a);
    host.xfer(1'b0, KIS_SZ_8, a, 32'h0000_0000, q);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, KIS_SZ_32, a, d, x);
  endtask : wr
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    `CHK(acc, `KIS_ACCURACY_RESET)
    wr(`KIS_ADDR_RUN, 32'h0000_0001);
    rd(`KIS_ADDR_RUN);
    `CHK(({q[0], run}), 2'b11)
    `CHK(zx, 16'hffff)
    // clock enable low: the write must not be taken and run must hold
    ce = 1'b0;
    wr(`KIS_ADDR_RUN, 32'h0000_0000);
    ce = 1'b1;
    rd(`KIS_ADDR_RUN);
    `CHK(({q[0], run, rsp.valid}), 3'b111)
    host.xfer(1'b1, KIS_SZ_8, `KIS_ADDR_ACCURACY, 32'h0000_0001, q);
    rd(`KIS_ADDR_ACCURACY);
    `CHK(q, 32'h0000_0000)
    host.unlock(32'h0000_0001, KIS_SZ_16);
    rd(`KIS_ADDR_ACCURACY);
    `CHK(q, 32'h0000_0000)
    host.xfer(1'b1, KIS_SZ_8, `KIS_ADDR_UNLOCK, 32'h0000_00ad, q);
    rd(`KIS_ADDR_UNLOCK);
    `CHK(q, 32'h0000_0000)
    host.xfer(1'b1, KIS_SZ_8, `KIS_ADDR_ACCURACY, 32'h0000_0001, q);
    rd(`KIS_ADDR_ACCURACY);
    `CHK(q, 32'h0000_0000)
    host.unlock(32'h0000_0001, KIS_SZ_8);
    rd(`KIS_ADDR_ACCURACY);
    `CHK(({rsp.valid, q}), ({1'b1, 32'h0000_0001}))
    `CHK(acc, `KIS_ACCURACY_BEST)
    wr(`KIS_ADDR_SAG_LEVEL, 32'h0000_0123);
    rd(`KIS_ADDR_STATUS);
    `CHK(q[3:0], 4'h4)
    `CHK(sag, 24'h00_0000)
    host.burst8(`KIS_ADDR_ZX_TIMEOUT, 32'h0000_0042);
    `CHK(zx, 16'h0042)
    host.idle();
    phase_mag[48 +: 24] = 24'h08_3378;
    repeat (4) @(posedge clk);
    #1;
    `CHK(seen, 1'b0)
    phase_mag[48 +: 24] = 24'h08_3379;
    repeat (4) @(posedge clk);
    #1;
    `CHK(({seen, sag}), ({1'b1, 24'h00_0123}))
    wr(`KIS_ADDR_ZX_TIMEOUT, 32'h0000_0077);
    `CHK(zx, 16'h0077)
    wr(`KIS_ADDR_SAG_LEVEL, 32'h0000_0055);
    `CHK(sag, 24'h00_0055)
    host.idle();
    summarize();
  end
endmodule : testbench
`default_nettype wire
